// *** hw/nv_seq_host.sv ***
// host sequencer: drives software save/recall, hardware-pin save, read cycles
// assumes an asynchronous parallel nonvolatile SRAM on the pins, one mclk domain
//
// Contract
// (R1) After power rises the device restores within 20 ms, so the host waits that long first.
// (R2) The device skips a save when nothing was written since the last nonvolatile operation.
// (R3) A save completes within 15 ms of its start, so the host waits that long.
// (R4) Each command step is a read cycle ended by chip select or output enable, both accepted.
// (R5) The host issues six reads of the fixed address list in order with write strobe high.
// (R6) The device acts on the command within 70 us after the sixth read.
// (R7) While a software save or restore runs, the host issues no data port access.
// (R8) After the save line is pulled low the host allows 70 us for a cycle in progress.
// (R9) The host holds the save line low for at least 15 ns.
// (R10) The host keeps the save line released during every ordinary read and write.
// (R11) A cycle that begins with write strobe low leaves the device outputs off.
// (R12) The host holds write strobe high during every read cycle.
// (R13) The six addresses and command codes are parameters.
`timescale 1ns/1ps
`default_nettype none
module nv_seq_host #(
	parameter int unsigned RECALL_UP_CYC_P = nv_seq_pkg::RECALL_UP_CYC,  // power-up wait
	parameter int unsigned STORE_CYC_P     = nv_seq_pkg::STORE_CYC,      // save wait
	parameter logic [89:0] SAVE_ADDRS      = 90'h0,  // six 15-bit addresses, step 0 low
	parameter logic [89:0] RECALL_ADDRS    = 90'h0   // six 15-bit addresses, step 0 low
) (
	input  wire logic                     mclk,        // 40 MHz clock
	input  wire logic                     rst,         // synchronous reset, high
	input  wire logic                     req_valid,   // request strobe
	input  wire logic [1:0]               req_cmd,     // read, save, recall, hw save
	input  wire logic [nv_seq_pkg::AW-1:0] req_addr,   // address for plain read
	output logic                          req_ready,   // idle, may take a request
	output logic                          done,        // one-cycle completion pulse
	output logic [7:0]                    rd_data,     // captured read data
	output nv_seq_pkg::mem_pins_s         pins,        // strobes and address
	input  wire logic [7:0]               dq_in,       // data bus from device
	input  wire logic                     nv_save_busy_line_in, // save line level
	output logic                          nv_save_busy_line_out, // always low when driven
	output logic                          nv_save_busy_line_oe   // high while pulled low
);
	nv_seq_pkg::state_e         st_q;
	logic [nv_seq_pkg::CNT_W-1:0] cnt_q;
	logic [2:0]                 step_q;
	logic                       soft_recall_q;
	logic [1:0]                 cmd_q;
	logic [nv_seq_pkg::AW-1:0]  addr_q;
	logic                       hsb_lvl;

	// ***********************************
	// pin synchroniser
	// ***********************************
	nv_pin_sync u_hsb_sync (
		.mclk  (mclk),
		.rst   (rst),
		.pin   (nv_save_busy_line_in),
		.level (hsb_lvl)
	);

	// ***********************************
	// decode
	// ***********************************
	wire logic [89:0] seq_tab = soft_recall_q ? RECALL_ADDRS : SAVE_ADDRS;  // [R13]
	wire logic [nv_seq_pkg::AW-1:0] next_addr = seq_tab[(step_q + 3'h1)*15 +: 15];  // [R5]
	wire logic [nv_seq_pkg::AW-1:0] first_addr = (req_cmd == nv_seq_pkg::CMD_READ) ? req_addr :
		(req_cmd == nv_seq_pkg::CMD_RECALL) ? RECALL_ADDRS[14:0] : SAVE_ADDRS[14:0];
	wire logic cnt_zero  = (cnt_q == '0);
	wire logic last_step = (step_q == 3'(nv_seq_pkg::STEPS - 1));
	wire logic take      = req_valid && req_ready;
	// soft steps alternate which strobe ends the read
	wire logic oe_ctl    = step_q[0];  // [R4]

	// ***********************************
	// sequencer
	// ***********************************
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			st_q                  <= nv_seq_pkg::ST_POWERUP;
			cnt_q                 <= nv_seq_pkg::CNT_W'(RECALL_UP_CYC_P);  // [R1]
			step_q                <= '0;
			soft_recall_q         <= 1'b0;
			cmd_q                 <= nv_seq_pkg::CMD_READ;
			addr_q                <= '0;
			req_ready             <= 1'b0;
			done                  <= 1'b0;
			rd_data               <= 8'h00;
			pins                  <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0};
			nv_save_busy_line_out <= 1'b0;
			nv_save_busy_line_oe  <= 1'b0;
		end
		else
		begin
			done  <= 1'b0;
			pins.we_n <= 1'b1;  // [R5] [R12] [R11]
			case (st_q)
			nv_seq_pkg::ST_POWERUP:
			begin
				cnt_q <= cnt_q - 1'b1;
				if (cnt_zero)
				begin
					st_q      <= nv_seq_pkg::ST_IDLE;  // [R1]
					req_ready <= 1'b1;
				end
			end
			nv_seq_pkg::ST_IDLE:
			begin
				nv_save_busy_line_oe <= 1'b0;  // [R10]
				if (take)
				begin
					req_ready     <= 1'b0;
					cmd_q         <= req_cmd;
					addr_q        <= req_addr;
					step_q        <= '0;
					soft_recall_q <= (req_cmd == nv_seq_pkg::CMD_RECALL);
					if (req_cmd == nv_seq_pkg::CMD_HWSAVE)
					begin
						st_q                 <= nv_seq_pkg::ST_HWLOW;
						cnt_q                <= nv_seq_pkg::CNT_W'(nv_seq_pkg::HSB_CYC);
						nv_save_busy_line_oe <= 1'b1;  // [R9]
					end
					else
					begin
						st_q  <= nv_seq_pkg::ST_STEP;
						cnt_q <= nv_seq_pkg::CNT_W'(nv_seq_pkg::RD_CYC);
						pins.ce_n <= 1'b0;
						pins.oe_n <= 1'b0;
						pins.addr <= first_addr;  // [R5]
					end
				end
			end
			nv_seq_pkg::ST_STEP:
			begin
				cnt_q <= cnt_q - 1'b1;
				if (cnt_zero)
				begin
					if (cmd_q == nv_seq_pkg::CMD_READ || !oe_ctl)
						pins.ce_n <= 1'b1;  // [R4]
					pins.oe_n <= 1'b1;
					rd_data   <= dq_in;
					st_q      <= nv_seq_pkg::ST_GAP;
				end
			end
			nv_seq_pkg::ST_GAP:
			begin
				if (cmd_q == nv_seq_pkg::CMD_READ)
				begin
					done      <= 1'b1;
					req_ready <= 1'b1;
					st_q      <= nv_seq_pkg::ST_IDLE;
				end
				else if (last_step)
				begin
					pins.ce_n <= 1'b1;
					// save worst case covers recall too
					cnt_q <= nv_seq_pkg::CNT_W'(nv_seq_pkg::SOFT_CYC + STORE_CYC_P);  // [R6] [R3] [R2]
					st_q  <= nv_seq_pkg::ST_BUSY;
				end
				else
				begin
					step_q    <= step_q + 3'h1;
					pins.addr <= next_addr;  // [R5]
					pins.ce_n <= 1'b0;
					pins.oe_n <= 1'b0;
					cnt_q     <= nv_seq_pkg::CNT_W'(nv_seq_pkg::RD_CYC);
					st_q      <= nv_seq_pkg::ST_STEP;
				end
			end
			nv_seq_pkg::ST_BUSY:
			begin
				cnt_q <= cnt_q - 1'b1;  // [R7]
				if (cnt_zero)
				begin
					done      <= 1'b1;
					req_ready <= 1'b1;
					st_q      <= nv_seq_pkg::ST_IDLE;
				end
			end
			nv_seq_pkg::ST_HWLOW:
			begin
				cnt_q <= cnt_q - 1'b1;
				if (cnt_zero)
				begin
					nv_save_busy_line_oe <= 1'b0;
					cnt_q <= nv_seq_pkg::CNT_W'(nv_seq_pkg::HW_DELAY_CYC + STORE_CYC_P);  // [R8] [R3]
					st_q  <= nv_seq_pkg::ST_HWWAIT;
				end
			end
			nv_seq_pkg::ST_HWWAIT:
			begin
				if (!cnt_zero)
					cnt_q <= cnt_q - 1'b1;
				else if (hsb_lvl)
				begin
					done      <= 1'b1;
					req_ready <= 1'b1;
					st_q      <= nv_seq_pkg::ST_IDLE;
				end
			end
			default:
				st_q <= nv_seq_pkg::ST_IDLE;
			endcase
		end
	end

	// ***********************************
	// checks
	// ***********************************
	we_high_read_a : assert property (@(posedge mclk) disable iff (rst)  // [R12]
		!pins.ce_n |-> pins.we_n)
		else $error("write strobe low during a read");

	hsb_idle_read_a : assert property (@(posedge mclk) disable iff (rst)  // [R10]
		!pins.ce_n |-> !nv_save_busy_line_oe)
		else $error("save line pulled during a cycle");

	hsb_pulse_a : assert property (@(posedge mclk) disable iff (rst)  // [R9]
		$rose(nv_save_busy_line_oe) |-> nv_save_busy_line_oe [*2])
		else $error("save pulse too short");

	busy_lock_a : assert property (@(posedge mclk) disable iff (rst)  // [R7]
		st_q == nv_seq_pkg::ST_BUSY |-> pins.ce_n && !req_ready)
		else $error("access during nonvolatile operation");

	busy_wait_a : assert property (@(posedge mclk) disable iff (rst)  // [R6]
		$rose(st_q == nv_seq_pkg::ST_BUSY) |-> !done [*8])
		else $error("soft command completed too early");

	step_count_a : assert property (@(posedge mclk) disable iff (rst)  // [R5]
		st_q == nv_seq_pkg::ST_BUSY |-> step_q == 3'(nv_seq_pkg::STEPS - 1))
		else $error("sequence ended before six reads");

	powerup_a : assert property (@(posedge mclk) disable iff (rst)  // [R1]
		st_q == nv_seq_pkg::ST_POWERUP |-> !req_ready && pins.ce_n)
		else $error("access before power-up restore");

	hw_wait_a : assert property (@(posedge mclk) disable iff (rst)  // [R8]
		$rose(st_q == nv_seq_pkg::ST_HWWAIT) |-> !req_ready [*8])
		else $error("hardware save wait cut short");

endmodule : nv_seq_host
`default_nettype wire

// *** hw/nv_seq_pkg.sv ***
// constants and carrier types for the nonvolatile store/recall host sequencer
// assumes a 40 MHz mclk; device pins are asynchronous to it
package nv_seq_pkg;

	localparam int unsigned CLK_NS          = 25;
	localparam int unsigned RECALL_UP_MS    = 20;    // power-up restore, longest
	localparam int unsigned STORE_MS        = 15;    // save duration, longest
	localparam int unsigned SOFT_PROC_US    = 70;    // soft sequence processing
	localparam int unsigned HW_DELAY_US     = 70;    // cycle completion before save
	localparam int unsigned HSB_PULSE_NS    = 15;    // save line low time, least
	localparam int unsigned RD_CYCLE_NS     = 45;    // read strobe width, least

	localparam int unsigned RECALL_UP_CYC = RECALL_UP_MS * 1000000 / CLK_NS;
	localparam int unsigned STORE_CYC     = STORE_MS * 1000000 / CLK_NS;
	localparam int unsigned SOFT_CYC      = SOFT_PROC_US * 1000 / CLK_NS;
	localparam int unsigned HW_DELAY_CYC  = HW_DELAY_US * 1000 / CLK_NS;
	localparam int unsigned HSB_CYC       = (HSB_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned RD_CYC        = (RD_CYCLE_NS + CLK_NS - 1) / CLK_NS;

	localparam int unsigned STEPS   = 6;
	localparam int unsigned AW      = 15;
	localparam int unsigned CNT_W   = 24;

	localparam logic [1:0] CMD_READ   = 2'h0;
	localparam logic [1:0] CMD_SAVE   = 2'h1;
	localparam logic [1:0] CMD_RECALL = 2'h2;
	localparam logic [1:0] CMD_HWSAVE = 2'h3;

	typedef enum {
		ST_POWERUP,
		ST_IDLE,
		ST_STEP,
		ST_GAP,
		ST_BUSY,
		ST_HWLOW,
		ST_HWWAIT
	} state_e;

	typedef struct packed {
		logic          ce_n;
		logic          oe_n;
		logic          we_n;
		logic [AW-1:0] addr;
	} mem_pins_s;

endpackage : nv_seq_pkg

// *** hw/nv_pin_sync.sv ***
// three-stage synchroniser with agreement filter for one device pin
// assumes the pin is asynchronous to mclk
`timescale 1ns/1ps
`default_nettype none
module nv_pin_sync (
	input  wire logic mclk,  // system clock
	input  wire logic rst,   // synchronous reset
	input  wire logic pin,   // raw pin level
	output var  logic level  // filtered level
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			s1_q  <= 1'b1;
			s2_q  <= 1'b1;
			s3_q  <= 1'b1;
			level <= 1'b1;
		end
		else
		begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q)
				level <= s3_q;
		end
	end
endmodule : nv_pin_sync
`default_nettype wire

// *** sim/nv_dev_model.sv ***
// behavioural nonvolatile sram with command recognition and save line
// assumes pins sampled on mclk; save line level resolved by the bench
`timescale 1ns/1ps
`default_nettype none
module nv_dev_model #(
	parameter logic [89:0] SAVE_A   = 90'h0,  // save command addresses
	parameter logic [89:0] RECALL_A = 90'h0,  // recall command addresses
	parameter int          BUSY     = 300,    // nonvolatile op length
	parameter int          RESTORE  = 10      // power-up restore length
) (
	input  wire logic                  mclk,     // clock
	input  wire logic                  rst,      // power-up event
	input  wire nv_seq_pkg::mem_pins_s pins,     // host strobes
	input  wire logic                  line,     // save line level
	output logic [7:0]                 dq,       // data bus
	output logic                       pull_low  // device holds line low
);
	// ****************************************
	// read tracking and lockout
	// ****************************************
	logic [14:0] log_q [0:31];
	logic [89:0] sh_q;
	logic [7:0]  last_q;
	logic        rd_q, hz_q, line_q, dirty_q;
	int          n_rd, cmds, busy_q;
	wire         rd = !pins.ce_n && !pins.oe_n;
	wire  [89:0] sh_d = {pins.addr, sh_q[89:15]};
	assign dq = (rd && !hz_q && busy_q == 0) ? pins.addr[7:0] ^ 8'h5A : ~last_q;
	always_ff @(posedge mclk)
	begin
		rd_q   <= rd;
		line_q <= line;
		last_q <= dq;
		if (pins.ce_n)
			hz_q <= !pins.we_n;
		if (rst)
		begin
			n_rd     <= 0;
			cmds     <= 0;
			busy_q   <= RESTORE;
			pull_low <= 1'b0;
			dirty_q  <= 1'b0;
		end
		else
		begin
			if (busy_q > 0)
				busy_q <= busy_q - 1;
			if (busy_q <= 1)
				pull_low <= 1'b0;
			if (!pins.ce_n && !pins.we_n)
				dirty_q <= 1'b1;
			if (rd_q && !rd && busy_q == 0)
			begin
				log_q[n_rd[4:0]] <= pins.addr;
				n_rd <= n_rd + 1;
				sh_q <= sh_d;
				if (sh_d == SAVE_A || sh_d == RECALL_A)
				begin
					cmds    <= cmds + 1;
					dirty_q <= 1'b0;
					busy_q <= (sh_d == SAVE_A && !dirty_q) ? 1 : BUSY;
				end
			end
			if (line_q && !line)
			begin
				busy_q   <= BUSY;
				pull_low <= 1'b1;
			end
		end
	end
endmodule : nv_dev_model
`default_nettype wire

// *** sim/nv_seq_host_tb.sv ***
// self-checking bench for the store/recall host sequencer
// assumes shortened wait parameters and the device model beside it
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
	$display("[FAIL] %s exp %h got %h", nm, e, g); end end
module nv_seq_host_tb;
	// ****************************************
	// wiring
	// ****************************************
	localparam logic [89:0] SA = {15'h7AB1, 15'h0E2C, 15'h1F3D, 15'h2A4E, 15'h35B0, 15'h4C61};
	localparam logic [89:0] RA = {15'h3C0E, 15'h0B1D, 15'h63F2, 15'h1E07, 15'h5A19, 15'h2D44};
	logic mclk = 0, rst = 1, req_valid = 0, req_ready, done, h_out, h_oe, pull;
	logic [1:0] req_cmd = 0;
	logic [14:0] req_addr = 0;
	logic [7:0] rd_data, dq;
	nv_seq_pkg::mem_pins_s pins;
	int fails = 0, samples_checked = 0, oe_cyc = 0, bad10 = 0, bad12 = 0;
	wire line = !((h_oe && !h_out) || pull);
	nv_seq_host #(.RECALL_UP_CYC_P(20), .STORE_CYC_P(20), .SAVE_ADDRS(SA), .RECALL_ADDRS(RA))
	i_dut (.mclk(mclk), .rst(rst), .req_valid(req_valid), .req_cmd(req_cmd),
		.req_addr(req_addr), .req_ready(req_ready), .done(done), .rd_data(rd_data),
		.pins(pins), .dq_in(dq), .nv_save_busy_line_in(line),
		.nv_save_busy_line_out(h_out), .nv_save_busy_line_oe(h_oe));
	nv_dev_model #(.SAVE_A(SA), .RECALL_A(RA)) i_dev (.mclk(mclk), .rst(rst), .pins(pins),
		.line(line), .dq(dq), .pull_low(pull));
	initial forever #12.5 mclk = ~mclk;
	always @(posedge mclk)
		if (!rst)
		begin
			if (h_oe === 1'b1) oe_cyc++;
			if (!pins.ce_n && h_oe !== 1'b0) bad10++;
			if (pins.we_n !== 1'b1) bad12++;
		end
	// ****************************************
	// tasks
	// ****************************************
	task give_verdict;
		$display("checked %0d fails %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	task automatic wait_on(ref logic s);
		int i;
		for (i = 0; i < 6000 && s !== 1'b1; i++) begin @(posedge mclk); #2; end
		if (i == 6000) begin fails++; give_verdict(); end
	endtask : wait_on
	task automatic do_req(input logic [1:0] c, input logic [14:0] a);
		wait_on(req_ready);
		req_valid = 1; req_cmd = c; req_addr = a;
		@(posedge mclk); #2;
		req_valid = 0;
		wait_on(done);
	endtask : do_req
	task automatic t_read(input logic [14:0] a);
		int n0;
		n0 = i_dev.n_rd;
		do_req(2'h0, a);
		`CHK("rd_data", a[7:0] ^ 8'h5A, rd_data)
		`CHK("reads", n0 + 1, i_dev.n_rd)
		$display("read %h done", a);
	endtask : t_read
	task automatic t_soft(input logic [1:0] c, input logic [89:0] aa);
		int n0, c0;
		n0 = i_dev.n_rd; c0 = i_dev.cmds;
		do_req(c, 15'h0);
		`CHK("steps", n0 + 6, i_dev.n_rd)
		`CHK("cmd seen", c0 + 1, i_dev.cmds)
		for (int k = 0; k < 6; k++)
			`CHK("step addr", aa[15*k +: 15], i_dev.log_q[(n0 + k) % 32])
		t_read(15'h0123);
		$display("soft command %0d done", c);
	endtask : t_soft
	task automatic t_hw;
		oe_cyc = 0;
		do_req(2'h3, 15'h0);
		`CHK("pulse", 1'b1, oe_cyc >= nv_seq_pkg::HSB_CYC)
		`CHK("line at done", 1'b1, line)
		`CHK("drive level", 1'b0, h_out)
		t_read(15'h7FFE);
		$display("hardware save done");
	endtask : t_hw
	// ****************************************
	// sequence
	// ****************************************
	initial
	begin
		int n;
		repeat (16) @(posedge mclk);
		#2 rst = 0;
		for (n = 0; n < 100 && req_ready !== 1'b1; n++) begin @(posedge mclk); #2; end
		`CHK("powerup wait", 1'b1, n >= 20)
		`CHK("powerup ready", 1'b1, req_ready)
		t_read(15'h1234);
		t_soft(2'h1, SA);
		t_soft(2'h2, RA);
		t_hw();
		`CHK("line in cycles", 0, bad10)
		`CHK("write strobe", 0, bad12)
		give_verdict();
	end
endmodule : nv_seq_host_tb
`default_nettype wire
